// file: design/bbsr_host.sv
// ahb-lite controlled host for a byte-wide battery-backed clock memory
// Behaviour
// - host keeps address stable during write
// - host gives strobe recovery before next cycle
// - host meets write data setup and hold
// - host keeps output enable high while writing
// - control bit 6 freezes time byte copy
// - control bit 7 halts, clear loads counters
module bbsr_host
	import bbsr_pkg::*;
(
	input  wire logic        hclk,           // 100 MHz clock
	input  wire logic        hresetn,        // async reset, active low
	input  wire logic        hsel,           // slave select
	input  wire logic [31:0] haddr,          // byte address
	input  wire logic [1:0]  htrans,         // transfer type
	input  wire logic        hwrite,         // write when high
	input  wire logic [2:0]  hsize,          // word only
	input  wire logic        hready,         // bus ready in
	input  wire logic [31:0] hwdata,         // write data
	output logic      [31:0] hrdata,         // read data
	output logic             hreadyout,      // always ready
	output logic             hresp,          // always okay
	output logic      [16:0] sram_addr,      // memory address pins
	output logic             sram_ce_n,      // chip enable, active low
	output logic             sram_oe_n,      // output enable, active low
	output logic             sram_we_n,      // write enable, active low
	output logic      [7:0]  data_bus_out,   // data driven to memory
	output logic             data_bus_oe_n,  // low while host drives data
	input  wire logic [7:0]  data_bus_in     // data pins as seen
);

	// ************************************************************
	// state
	// ************************************************************
	bbsr_state_e state;           // pin sequencer state
	bbsr_state_e next_state;      // its next value
	logic [3:0]  cnt;             // cycles in current state
	logic [3:0]  next_cnt;        // its next value
	logic        op_write;        // current access is a write
	logic        next_op;         // its next value
	logic [16:0] mem_addr;        // address register
	logic [7:0]  wdata;           // write byte register
	logic [7:0]  rdata;           // read byte register
	logic [7:0]  next_rdata;      // its next value
	logic        done;            // sticky completion flag
	logic [1:0]  halt;            // last control byte halt bits
	logic [16:0] next_addr;       // next address pins
	logic [7:0]  next_dout;       // next data pins
	logic        next_ce;         // next chip enable
	logic        next_oe;         // next output enable
	logic        next_we;         // next write enable
	logic        next_doe;        // next data drive enable
	logic        done_evt;        // access finished this cycle
	logic [7:0]  data_sync;       // synchronised data pins
	logic        ph_wr;           // data phase of a write pending
	logic [7:0]  ph_ofs;          // its register offset
	logic [31:0] read_mux;        // register read selection

	// ************************************************************
	// bus decode
	// ************************************************************
	wire addr_ok  = hsel & hready & htrans[1];              // valid address phase
	wire wr_ctrl  = ph_wr & (ph_ofs == OFS_CTRL);           // go command
	wire wr_addr  = ph_wr & (ph_ofs == OFS_ADDR);
	wire wr_wdata = ph_wr & (ph_ofs == OFS_WDATA);
	wire wr_stat  = ph_wr & (ph_ofs == OFS_STATUS);
	wire busy     = (state != ST_IDLE);
	// a go while busy is dropped: the pin cycle in flight must finish
	wire go_req   = wr_ctrl & hwdata[CTRL_GO_BIT] & ~busy;
	wire done_clr = wr_stat & hwdata[STAT_DONE_BIT];
	wire next_busy = (next_state != ST_IDLE);
	wire ctrl_hit  = (sram_addr == RTC_CTRL_ADDR);          // control byte access

	assign read_mux =
		(haddr[7:0] == OFS_CTRL)   ? {30'h0, op_write, busy} :
		(haddr[7:0] == OFS_ADDR)   ? {15'h0, mem_addr} :
		(haddr[7:0] == OFS_WDATA)  ? {24'h0, wdata} :
		(haddr[7:0] == OFS_RDATA)  ? {24'h0, rdata} :
		(haddr[7:0] == OFS_STATUS) ? {28'h0, halt, done, busy} :
		32'h0;                                              // unmapped reads zero

	assign hreadyout = 1'b1;  // zero wait states
	assign hresp     = 1'b0;  // okay only

	// ************************************************************
	// ahb slave registers
	// ************************************************************
	// capture address phase, answer reads from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr  <= 1'b0;
			ph_ofs <= 8'h00;
			hrdata <= 32'h0;
		end else begin
			ph_wr  <= addr_ok & hwrite;
			ph_ofs <= haddr[7:0];
			if (addr_ok & ~hwrite) begin
				hrdata <= read_mux;
			end
		end
	end

	// software-written registers and flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_addr <= RST_ADDR;
			wdata    <= RST_BYTE;
			done     <= 1'b0;
			halt     <= 2'b00;
		end else begin
			if (wr_addr) begin
				mem_addr <= hwdata[16:0];  // 17 address bits
			end
			if (wr_wdata) begin
				wdata <= hwdata[7:0];
			end
			// completion set wins over a clear in the same cycle
			if (done_evt) begin
				done <= 1'b1;
			end else if (done_clr | go_req) begin
				done <= 1'b0;
			end
			// mirror halt bits written to the control byte
			if (done_evt & op_write & ctrl_hit) begin
				halt <= data_bus_out[RTC_WRITE_BIT:RTC_READ_BIT];
			end
		end
	end

	// ************************************************************
	// pin sequencer
	// ************************************************************
	// time and control bytes go through the same cycles as any byte
	always_comb begin
		next_state = state;
		next_cnt   = 4'(cnt + 4'h1);
		next_op    = op_write;
		next_addr  = sram_addr;
		next_dout  = data_bus_out;
		next_ce    = sram_ce_n;
		next_oe    = sram_oe_n;
		next_we    = sram_we_n;
		next_doe   = data_bus_oe_n;
		next_rdata = rdata;
		done_evt   = 1'b0;
		unique case (state)
			ST_IDLE: begin
				next_cnt = 4'h0;
				if (go_req) begin
					// address settles a cycle before any strobe
					next_state = ST_ADDR;
					next_op    = hwdata[CTRL_WR_BIT];
					next_addr  = mem_addr;
					next_dout  = wdata;
					next_doe   = ~hwdata[CTRL_WR_BIT];  // data set up from the start
				end
			end
			ST_ADDR: begin
				next_cnt = 4'h0;
				next_ce  = 1'b0;
				if (op_write) begin
					// both fall together, oe stays high
					next_we    = 1'b0;
					next_state = ST_WR;
				end else begin
					next_oe    = 1'b0;  // read with we high
					next_state = ST_RD;
				end
			end
			ST_RD: begin
				// wait the slowest access time plus the sync delay
				if (cnt == RD_LAST) begin
					next_rdata = data_sync;
					next_ce    = 1'b1;
					next_oe    = 1'b1;
					next_cnt   = 4'h0;
					next_state = ST_FLOAT;
				end
			end
			ST_FLOAT: begin
				// device must float before anyone drives again
				if (cnt == FLOAT_LAST) begin
					done_evt   = 1'b1;
					next_state = ST_IDLE;
				end
			end
			ST_WR: begin
				if (cnt == WR_LAST) begin
					next_ce    = 1'b1;  // both rise together to end the write
					next_we    = 1'b1;
					next_cnt   = 4'h0;
					next_state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// data and address held, strobes recover
				if (cnt == HOLD_LAST) begin
					next_doe   = 1'b1;
					done_evt   = 1'b1;
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	// sequencer and pin flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state         <= ST_IDLE;
			cnt           <= 4'h0;
			op_write      <= 1'b0;
			rdata         <= RST_BYTE;
			sram_addr     <= RST_ADDR;
			data_bus_out  <= RST_BYTE;
			sram_ce_n     <= 1'b1;
			sram_oe_n     <= 1'b1;
			sram_we_n     <= 1'b1;
			data_bus_oe_n <= 1'b1;
		end else begin
			state         <= next_state;
			cnt           <= next_cnt;
			op_write      <= next_op;
			rdata         <= next_rdata;
			sram_addr     <= next_addr;
			data_bus_out  <= next_dout;
			sram_ce_n     <= next_ce;
			sram_oe_n     <= next_oe;
			sram_we_n     <= next_we;
			data_bus_oe_n <= next_doe;
		end
	end

	// pins come from outside hclk
	bbsr_sync u_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.pin_in   (data_bus_in),
		.pin_sync (data_sync)
	);

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_wr_pulse;
		(!sram_we_n && !sram_ce_n && sram_oe_n)[*7] ##1 (sram_we_n && sram_ce_n);
	endsequence
	sequence s_wr_hold;
		(!data_bus_oe_n && $stable(data_bus_out) && $stable(sram_addr))[*2] ##1 data_bus_oe_n;
	endsequence
	sequence s_rd_strobe;
		(!sram_ce_n && !sram_oe_n)[*8] ##1 (!sram_ce_n && !sram_oe_n)[*3] ##1 (sram_ce_n && sram_oe_n);
	endsequence

	a_oe_in_write:   assert property (!sram_we_n |-> sram_oe_n)
		else $error("output enable low during write");
	a_drive_no_oe:   assert property (!data_bus_oe_n |-> sram_oe_n)
		else $error("host drives data while memory output enabled");
	a_write_pulse:   assert property ($fell(sram_we_n) |-> s_wr_pulse)
		else $error("write pulse length or shape wrong");
	a_write_hold:    assert property ($rose(sram_we_n) |-> s_wr_hold)
		else $error("write data or address not held after write");
	a_addr_stable:   assert property ((!sram_ce_n && $past(!sram_ce_n)) |-> $stable(sram_addr))
		else $error("address moved during access");
	a_ce_recovery:   assert property ($rose(sram_ce_n) |-> sram_ce_n[*3])
		else $error("chip enable recovery too short");
	a_read_strobe:   assert property (($fell(sram_ce_n) && sram_we_n) |-> s_rd_strobe)
		else $error("read strobes not held for access time");
	a_read_float:    assert property ($rose(sram_oe_n) |-> data_bus_oe_n[*3])
		else $error("host drove data before memory floated");
	a_done_flag:     assert property ((busy && !next_busy) |=> (done && !busy))
		else $error("completion not flagged");

endmodule

// file: design/bbsr_pkg.sv
// constants shared by the byte-wide clock-memory host controller
package bbsr_pkg;

	// ************************************************************
	// clock and pin timing
	// ************************************************************
	localparam int CLK_PERIOD_NS        = 10;  // hclk period
	localparam int ADDRESS_ACCESS_TIME  = 85;  // address valid to data valid, ns
	localparam int T_CE_ACCESS_NS       = 85;  // chip enable low to data valid
	localparam int T_OE_ACCESS_NS       = 55;  // output enable low to data valid
	localparam int T_OUT_FLOAT_NS       = 30;  // strobe high to data float
	localparam int T_WE_PULSE_NS        = 60;  // least write enable pulse
	localparam int T_CE_PULSE_NS        = 65;  // least chip enable pulse
	localparam int T_ADDR_TO_END_NS     = 70;  // address valid to write end
	localparam int T_DATA_SETUP_NS      = 35;  // data valid to write end
	localparam int T_END_HOLD_NS        = 15;  // data and address hold after write end
	localparam int SYNC_CYC             = 2;   // data pins pass two flip-flops

	// least times round up to whole cycles
	localparam int T_RD_NS   = (ADDRESS_ACCESS_TIME > T_CE_ACCESS_NS) ? ADDRESS_ACCESS_TIME : T_CE_ACCESS_NS;
	localparam int T_RD2_NS  = (T_RD_NS > T_OE_ACCESS_NS) ? T_RD_NS : T_OE_ACCESS_NS;
	localparam int T_WA_NS   = (T_WE_PULSE_NS > T_CE_PULSE_NS) ? T_WE_PULSE_NS : T_CE_PULSE_NS;
	localparam int T_WR_NS   = (T_WA_NS > T_ADDR_TO_END_NS) ? T_WA_NS : T_ADDR_TO_END_NS;
	localparam int T_WR2_NS  = (T_WR_NS > T_DATA_SETUP_NS) ? T_WR_NS : T_DATA_SETUP_NS;
	localparam int RD_CYC    = (T_RD2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_CYC    = (T_WR2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC  = (T_END_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLOAT_CYC = (T_OUT_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [3:0] RD_LAST    = 4'(RD_CYC + SYNC_CYC - 1);
	localparam logic [3:0] WR_LAST    = 4'(WR_CYC - 1);
	localparam logic [3:0] HOLD_LAST  = 4'(HOLD_CYC - 1);
	localparam logic [3:0] FLOAT_LAST = 4'(FLOAT_CYC - 1);

	// ************************************************************
	// controller registers on the ahb side
	// ************************************************************
	localparam logic [7:0] OFS_CTRL   = 8'h00;  // go and direction
	localparam logic [7:0] OFS_ADDR   = 8'h04;  // 17-bit memory address
	localparam logic [7:0] OFS_WDATA  = 8'h08;  // byte to write
	localparam logic [7:0] OFS_RDATA  = 8'h0C;  // byte last read
	localparam logic [7:0] OFS_STATUS = 8'h10;  // busy, done, clock halt view
	localparam int CTRL_GO_BIT   = 0;
	localparam int CTRL_WR_BIT   = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_HALT_LSB = 2;

	// ************************************************************
	// device map: clock control byte and time bytes
	// ************************************************************
	localparam logic [16:0] RTC_CTRL_ADDR  = 17'h1FFF8;
	localparam logic [16:0] RTC_TIME_FIRST = 17'h1FFF9;
	localparam logic [16:0] RTC_TIME_LAST  = 17'h1FFFF;
	localparam int RTC_WRITE_BIT = 7;  // halts copying, loads counters on clear
	localparam int RTC_READ_BIT  = 6;  // freezes the per-second copy

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [16:0] RST_ADDR  = 17'h00000;
	localparam logic [7:0]  RST_BYTE  = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_RD, ST_FLOAT, ST_WR, ST_HOLD
	} bbsr_state_e;

endpackage

// file: design/bbsr_sync.sv
// two-flop synchroniser for the data pins read back from the memory
module bbsr_sync
	import bbsr_pkg::*;
(
	input  wire logic       hclk,      // system clock
	input  wire logic       hresetn,   // async reset, active low
	input  wire logic [7:0] pin_in,    // raw data pins
	output logic      [7:0] pin_sync   // pins after two flops
);

	// ************************************************************
	// per-bit double flop
	// ************************************************************
	logic [7:0] meta;  // first stage, read only by the second

	generate
		for (genvar i = 0; i < 8; i++) begin : g_bit
			// pins settle asynchronously to hclk
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					meta[i]     <= 1'b0;
					pin_sync[i] <= 1'b0;
				end else begin
					meta[i]     <= pin_in[i];
					pin_sync[i] <= meta[i];
				end
			end
		end
	endgenerate

endmodule

// file: tb/bbsr_dev_model.sv
// behavioural clock memory answering the host controller's pins
module bbsr_dev_model
	import bbsr_pkg::*;
(
	input  wire logic [16:0] sram_addr,  // address pins
	input  wire logic        sram_ce_n,  // chip enable, active low
	input  wire logic        sram_oe_n,  // output enable, active low
	input  wire logic        sram_we_n,  // write enable, active low
	input  wire logic [7:0]  data_bus,   // resolved data wire
	input  wire logic        pwr_bad,    // supply out of tolerance
	input  wire logic        tick_1hz,   // one-second tick
	output logic             dev_oe,     // device drives the wire
	output logic      [7:0]  dev_q       // byte it drives
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// array, counter and access timing
	// ************************************************************
	logic [7:0]  mem [0:131071];  // time bytes sit in the array
	logic [7:0]  cnt_t [1:7];     // real counters: sec, min, hour, day, date, month, year, bcd
	wire  [18:0] pins = {sram_addr, sram_ce_n, sram_oe_n};  // what restarts an access
	wire  [18:0] pins_d;                                    // pins after the access time
	wire         wr_on = ~sram_ce_n & ~sram_we_n & ~pwr_bad; // write window
	wire         halt = mem[RTC_CTRL_ADDR][RTC_READ_BIT] | mem[RTC_CTRL_ADDR][RTC_WRITE_BIT];
	// inertial delay: any change restarts the wait, so early data is wrong
	assign #(ADDRESS_ACCESS_TIME) pins_d = pins;
	// drives only in read mode with output enable low
	assign dev_oe = ~sram_ce_n & ~sram_oe_n & sram_we_n & ~pwr_bad;
	assign dev_q  = (pins_d === pins) ? mem[sram_addr] : ~mem[sram_addr];
	initial begin
		for (int i = 0; i < 131072; i++)
			mem[i] = 8'h00;
		cnt_t = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};  // midnight, day 1, 1 jan, year 00
	end
	// bcd step that wraps from top back to first
	function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top, input logic [7:0] first);
		if (v == top)
			return first;
		if (v[3:0] == 4'h9)
			return {4'(v[7:4] + 4'h1), 4'h0};
		return v + 8'h01;
	endfunction
	// month length; every fourth year is leap, so it holds only up to 2099
	function automatic logic [7:0] mdays(input logic [7:0] mon, input logic [7:0] yr);
		if (mon == 8'h02)
			return ((((yr[4] ? 4'h2 : 4'h0) + yr[3:0]) & 4'h3) == 4'h0) ? 8'h29 : 8'h28;
		if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
			return 8'h30;
		return 8'h31;
	endfunction
	// carry chain: day and date both step when the hour wraps, other stages only when the one below wraps, 24-hour day
	task automatic count_up;
		cnt_t[1] = bcd_inc(cnt_t[1], 8'h59, 8'h00);
		if (cnt_t[1] != 8'h00)
			return;
		cnt_t[2] = bcd_inc(cnt_t[2], 8'h59, 8'h00);
		if (cnt_t[2] != 8'h00)
			return;
		cnt_t[3] = bcd_inc(cnt_t[3], 8'h23, 8'h00);
		if (cnt_t[3] != 8'h00)
			return;
		cnt_t[4] = bcd_inc(cnt_t[4], 8'h07, 8'h01);
		cnt_t[5] = bcd_inc(cnt_t[5], mdays(cnt_t[6], cnt_t[7]), 8'h01);
		if (cnt_t[5] != 8'h01)
			return;
		cnt_t[6] = bcd_inc(cnt_t[6], 8'h12, 8'h01);
		if (cnt_t[6] != 8'h01)
			return;
		cnt_t[7] = bcd_inc(cnt_t[7], 8'h99, 8'h00);
	endtask
	// write lands at the earlier rise of the two strobes
	always @(negedge wr_on) begin
		if (!pwr_bad) begin
			if (sram_addr == RTC_CTRL_ADDR && mem[RTC_CTRL_ADDR][RTC_WRITE_BIT] && !data_bus[RTC_WRITE_BIT])
				for (int k = 1; k < 8; k++)
					cnt_t[k] = mem[RTC_CTRL_ADDR + k];  // clearing the write bit loads all counters
			mem[sram_addr] = data_bus;
		end
	end
	// per-second copy of all seven bytes, skipped while halted or a write is open
	always @(posedge tick_1hz) begin
		count_up;
		if (!halt && !wr_on)
			for (int k = 1; k < 8; k++)
				mem[RTC_CTRL_ADDR + k] = cnt_t[k];
	end
endmodule

// file: tb/tb_top.sv
// testbench for the ahb-lite clock-memory host controller
module tb_top
	import bbsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// signals and instances
	// ************************************************************
	logic        hclk, hresetn, hsel, hwrite, tick;  // bench driven
	logic [31:0] haddr, hwdata, hrdata, q;           // bus words
	logic [1:0]  htrans;                             // transfer type
	logic [2:0]  hsize;                              // always word
	logic        hreadyout, hresp;                   // slave answer
	logic [16:0] sram_addr, a_q;                     // pins, last seen
	logic        sram_ce_n, sram_oe_n, sram_we_n;    // strobes
	logic [7:0]  data_bus_out, dev_q;                // both drivers
	logic        data_bus_oe_n, dev_oe, wr_seen;     // enables
	logic [7:0]  flt = 8'h00;                        // floating pattern
	logic        pwr;                                // supply fault seen by the memory
	logic [7:0]  t_set [0:6] = '{8'h59, 8'h59, 8'h23, 8'h01, 8'h28, 8'h02, 8'h04};  // 23:59:59, 28 feb, leap year
	int          n_mismatch, num_checks, lo, hi, n_acc, n0;
	// no pull-up: released wire shows a toggling pattern
	wire [7:0] data_bus_in = (data_bus_oe_n === 1'b0) ? data_bus_out : (dev_oe ? dev_q : flt);
	bbsr_host dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sram_addr(sram_addr), .sram_ce_n(sram_ce_n),
		.sram_oe_n(sram_oe_n), .sram_we_n(sram_we_n), .data_bus_out(data_bus_out),
		.data_bus_oe_n(data_bus_oe_n), .data_bus_in(data_bus_in));
	bbsr_dev_model dev_u (.sram_addr(sram_addr), .sram_ce_n(sram_ce_n), .sram_oe_n(sram_oe_n),
		.sram_we_n(sram_we_n), .data_bus(data_bus_in), .pwr_bad(pwr), .tick_1hz(tick),
		.dev_oe(dev_oe), .dev_q(dev_q));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk)
		flt <= ~data_bus_in;
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic close_out;
		if (n_mismatch == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one edge with ready high, bounded so a stuck slave ends the run
	task automatic edge_rdy;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (i >= 50) begin
			n_mismatch++;
			close_out;
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= 3'b010;
		edge_rdy;
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		edge_rdy;
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(nm, exp, q);
	endtask
	// one memory access; dbl sends a second go while busy
	task automatic mem_op(input logic wr, input logic [16:0] a, input logic [7:0] d, input logic dbl);
		int i;
		ahb(1'b1, OFS_ADDR, {15'h0, a});
		ahb(1'b1, OFS_WDATA, {24'h0, d});
		ahb(1'b1, OFS_CTRL, {30'h0, wr, 1'b1});
		if (dbl)
			ahb(1'b1, OFS_CTRL, {30'h0, wr, 1'b1});
		for (i = 0; i < 40; i++) begin
			ahb(1'b0, OFS_STATUS, 32'h0);
			if (q[STAT_DONE_BIT] === 1'b1)
				break;
		end
		if (i >= 40) begin
			n_mismatch++;
			close_out;
		end
	endtask
	task automatic mem_rd(input string nm, input logic [16:0] a, input logic [7:0] exp);
		mem_op(1'b0, a, 8'h00, 1'b0);
		rchk(nm, OFS_RDATA, {24'h0, exp});
	endtask
	task automatic tick_pulse;
		tick <= 1'b1;
		@(posedge hclk);
		tick <= 1'b0;
		@(posedge hclk);
	endtask
	// ************************************************************
	// pin monitor: strobe lengths, recovery, contention
	// ************************************************************
	always @(posedge hclk) begin
		if (hresetn === 1'b1) begin
			if (sram_ce_n === 1'b0) begin
				if (lo == 0)
					chk("ce_recovery", 32'h1, {31'h0, hi >= 3});
				if (lo == 0)
					n_acc++;
				if (lo > 0)
					chk("addr_held", {15'h0, a_q}, {15'h0, sram_addr});
				chk("contention", 32'h0, {31'h0, ~data_bus_oe_n & dev_oe});
				if (sram_we_n === 1'b0)
					chk("oe_in_write", 32'h1, {31'h0, sram_oe_n});
				wr_seen = ~sram_we_n;
				lo++;
				hi = 0;
			end else begin
				if (lo > 0)
					chk("strobe_len", wr_seen ? WR_CYC : RD_CYC + SYNC_CYC, lo);
				if (lo > 0 && wr_seen)
					chk("data_hold", 32'h0, {31'h0, data_bus_oe_n});
				lo = 0;
				hi++;
			end
			a_q = sram_addr;
		end
	end
	initial begin
		#400000;
		n_mismatch++;
		close_out;
	end
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		tick = 1'b0;
		pwr = 1'b0;
		hi = 99;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("idle_pins", 32'hF, {28'h0, sram_ce_n, sram_oe_n, sram_we_n, data_bus_oe_n});
		rchk("status_rst", OFS_STATUS, 32'h0);
		mem_op(1'b1, 17'h00000, 8'hA5, 1'b0);
		mem_op(1'b1, 17'h12345, 8'h3C, 1'b0);
		mem_op(1'b1, 17'h1FFF7, 8'hFF, 1'b0);
		mem_rd("rd_low", 17'h00000, 8'hA5);
		mem_rd("rd_mid", 17'h12345, 8'h3C);
		mem_rd("rd_top", 17'h1FFF7, 8'hFF);
		ahb(1'b1, 8'h20, 32'hFFFFFFFF);
		rchk("unmapped", 8'h20, 32'h0);
		mem_op(1'b1, RTC_CTRL_ADDR, 8'h00, 1'b0);
		tick_pulse;
		mem_rd("sec_copy", RTC_TIME_FIRST, 8'h01);
		mem_op(1'b1, RTC_CTRL_ADDR, 8'h40, 1'b0);
		rchk("read_halt_view", OFS_STATUS, 32'h6);
		tick_pulse;
		mem_rd("sec_frozen", RTC_TIME_FIRST, 8'h01);
		mem_op(1'b1, RTC_CTRL_ADDR, 8'h80, 1'b0);
		rchk("write_halt_view", OFS_STATUS, 32'hA);
		mem_op(1'b1, RTC_TIME_FIRST, 8'h30, 1'b0);
		tick_pulse;
		mem_rd("sec_loaded", RTC_TIME_FIRST, 8'h30);
		mem_op(1'b1, RTC_CTRL_ADDR, 8'h00, 1'b0);
		tick_pulse;
		mem_rd("sec_after_load", RTC_TIME_FIRST, 8'h31);
		mem_op(1'b1, RTC_CTRL_ADDR, 8'h80, 1'b0);
		foreach (t_set[k])
			mem_op(1'b1, RTC_TIME_FIRST + 17'(k), t_set[k], 1'b0);
		mem_op(1'b1, RTC_CTRL_ADDR, 8'h00, 1'b0);
		tick_pulse;
		mem_rd("leap_date", 17'h1FFFD, 8'h29);
		mem_rd("day_roll", 17'h1FFFC, 8'h02);
		mem_rd("hour_roll", 17'h1FFFB, 8'h00);
		ahb(1'b1, OFS_STATUS, 32'h2);
		rchk("done_cleared", OFS_STATUS, 32'h0);
		pwr <= 1'b1;
		mem_op(1'b1, 17'h12345, 8'h5A, 1'b0);
		pwr <= 1'b0;
		mem_rd("rd_pwr_bad", 17'h12345, 8'h3C);
		n0 = n_acc;
		mem_op(1'b0, 17'h12345, 8'h00, 1'b1);
		chk("one_access", n0 + 1, n_acc);
		rchk("rd_after_dbl", OFS_RDATA, 32'h3C);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		rchk("status_rst2", OFS_STATUS, 32'h0);
		rchk("rdata_rst", OFS_RDATA, 32'h0);
		close_out;
	end
endmodule
